/* verilog/scc_map.vh */
// register map, field layout, reset values and timing figures of the channel controller
`ifndef SCC_MAP_VH
`define SCC_MAP_VH

// register byte offsets
`define SCC_ADDR_CH_CFG0 6'h00
`define SCC_ADDR_CH_CFG1 6'h04
`define SCC_ADDR_CH_CFG2 6'h08
`define SCC_ADDR_CH_CFG3 6'h0C
`define SCC_ADDR_STATUS 6'h10
`define SCC_ADDR_MASK 6'h14
`define SCC_ADDR_HOST_TMO 6'h18
`define SCC_ADDR_DIAG 6'h1C
`define SCC_ADDR_DATA0 6'h20
`define SCC_ADDR_DATA1 6'h24
`define SCC_ADDR_DATA2 6'h28
`define SCC_ADDR_DATA3 6'h2C

// channel config fields
`define SCC_CFG_OSR_LSB 0
`define SCC_CFG_OSR_MSB 3
`define SCC_CFG_SPD_BIT 4
`define SCC_CFG_EXC_LSB 5
`define SCC_CFG_EXC_MSB 6
`define SCC_CFG_RESET 7'h00

// oversample ratio codes: 0 -> 64 ... 9 -> 32768
`define SCC_OSR_CODE_MAX 4'h9

// excitation level codes
`define SCC_EXC_1V25 2'h0
`define SCC_EXC_2V 2'h1
`define SCC_EXC_3V 2'h2
`define SCC_EXC_5V 2'h3

// status / mask bit positions
`define SCC_ST_DRDY_LSB 0
`define SCC_ST_TEST_DONE 4
`define SCC_ST_TEST_FAIL 5
`define SCC_ST_CFG_ERR 6
`define SCC_ST_WIDTH 7
`define SCC_MASK_RESET 7'h00

// host timeout register, in milliseconds, zero disables
`define SCC_TMO_WIDTH 16
`define SCC_TMO_RESET 16'h0000

// timing
`define SCC_CLK_HZ 125000000
`define SCC_RATE64_HZ_X10 35156
`define SCC_MS_PER_S 1000
`define SCC_CONV_BASE 26'd35555
`define SCC_MS_CYCLES 17'd125000
`define SCC_HB_HALF_MS 16'd250
`define SCC_WD_MS 16'd100
`define SCC_TEST_CYCLES 16

`endif

/* verilog/scc_chan.v */
// one sensor channel: conversion timer and output latency pipeline
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.vh"

module scc_chan #(
	parameter DW = 24,
	parameter CW = 26,
	parameter [CW-1:0] CONV_BASE = 26'd35555
) (
	// clock and reset
	input wire ref_clk,
	input wire srst,
	// configuration
	input wire run,
	input wire [3:0] oversample_ratio,
	input wire spd_en,
	// converter side
	input wire [DW-1:0] adc_data,
	output reg conv_start_reg,
	// result
	output reg [DW-1:0] data_reg,
	output reg drdy_reg
);
	reg [CW-1:0] cnt_reg;
	reg [DW-1:0] stage_reg;
	wire [CW-1:0] period;
	wire [CW-1:0] full_period;

	// rate halves with each doubling of the ratio
	assign full_period = CONV_BASE << oversample_ratio;
	// multiplier doubles the rate, filter setting untouched
	assign period = spd_en ? (full_period >> 1) : full_period;

	always @(posedge ref_clk) begin
		if (srst) begin
			cnt_reg <= {CW{1'b0}};
			conv_start_reg <= 1'b0;
			stage_reg <= {DW{1'b0}};
			data_reg <= {DW{1'b0}};
			drdy_reg <= 1'b0;
		end else begin
			conv_start_reg <= 1'b0;
			drdy_reg <= 1'b0;
			if (!run) begin
				cnt_reg <= {CW{1'b0}};
			end else if (cnt_reg == {CW{1'b0}}) begin
				cnt_reg <= period - {{(CW-1){1'b0}}, 1'b1};
				conv_start_reg <= 1'b1;
				stage_reg <= adc_data;
				drdy_reg <= 1'b1;
				// one extra conversion of latency while multiplier is on
				data_reg <= spd_en ? stage_reg : adc_data;
			end else begin
				cnt_reg <= cnt_reg - {{(CW-1){1'b0}}, 1'b1};
			end
		end
	end
endmodule // scc_chan

`default_nettype wire

/* verilog/scc_top.v */
// sensor channel conversion control: registers, supervision, diagnostics
// Functional notes
// - four channels, each with its own converter timer and excitation setting.
// - each channel holds a ratio code and a speed multiplier bit.
// - ratio 64 to 32768 in powers of two; rate halves per doubling.
// - speed multiplier enabled doubles the channel conversion rate.
// - multiplier changes the rate and the data latency, filter ratio unchanged.
// - multiplier on adds exactly one conversion of data latency.
// - host picks one of four excitation levels; device drives it.
// - watchdog resets the module, all but the reset cause, when internal logic stops servicing it.
// - module resets when host is silent longer than programmed timeout.
// - self-test runs after every reset; faults shown on indicators.
// - drive power, heartbeat and host communication indicators.
//
// The register offsets and the Avalon-MM register port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.vh"

module scc_top #(
	parameter DW = 24,
	parameter [25:0] CONV_BASE = `SCC_CONV_BASE,
	parameter [16:0] MS_CYCLES = `SCC_MS_CYCLES,
	parameter [15:0] HB_HALF_MS = `SCC_HB_HALF_MS,
	parameter [15:0] WD_MS = `SCC_WD_MS
) (
	// clock and reset
	input wire ref_clk,
	input wire rst,
	// avalon-mm slave
	input wire [5:0] avs_address,
	input wire avs_read,
	input wire avs_write,
	input wire [31:0] avs_writedata,
	output reg [31:0] avs_readdata,
	output wire avs_waitrequest,
	output wire irq,
	// converters
	input wire [4*DW-1:0] adc_data,
	output wire [3:0] conv_start,
	// excitation supplies, two bits per channel
	output reg [7:0] exc_level,
	input wire [3:0] exc_pwr_good,
	// diagnostic indicators
	output reg led_power,
	output reg led_heartbeat,
	output reg led_comm
);
	localparam S_TEST = 3'b001;
	localparam S_RUN = 3'b010;
	localparam S_FAIL = 3'b100;

	function onehot3;
		input [2:0] s;
		begin
			onehot3 = (s == S_TEST) || (s == S_RUN) || (s == S_FAIL);
		end
	endfunction

	reg [2:0] state_reg;
	reg [4:0] test_cnt_reg;
	reg test_bad_reg;
	reg [27:0] cfg_reg;
	reg [`SCC_ST_WIDTH-1:0] status_reg;
	reg [`SCC_ST_WIDTH-1:0] mask_reg;
	reg [`SCC_TMO_WIDTH-1:0] tmo_reg;
	reg ack_reg;
	reg [16:0] ms_cnt_reg;
	reg [15:0] host_cnt_reg;
	reg [15:0] wd_cnt_reg;
	reg [15:0] hb_cnt_reg;
	reg [1:0] cause_reg;
	reg wd_rst_reg;
	reg tmo_rst_reg;
	wire srst;
	wire req;
	wire acc;
	wire wr;
	wire ms_tick;
	wire run;
	wire [3:0] drdy;
	wire [4*DW-1:0] chan_data;
	wire [`SCC_ST_WIDTH-1:0] st_set;
	wire [3:0] wr_osr;

	// any module-level reset source clears the whole block except the reset cause in cause_reg
	assign srst = rst | wd_rst_reg | tmo_rst_reg;

	// bus handshake: every access answered on the second cycle
	assign req = avs_read | avs_write;
	assign avs_waitrequest = req & ~ack_reg;
	assign acc = req & ack_reg;
	assign wr = avs_write & ack_reg;
	assign wr_osr = avs_writedata[`SCC_CFG_OSR_MSB:`SCC_CFG_OSR_LSB];
	assign run = (state_reg == S_RUN);
	assign ms_tick = (ms_cnt_reg == 17'h00000);

	// four independent channels
	genvar g;
	generate
		for (g = 0; g < 4; g = g + 1) begin : gen_chan
			scc_chan #(
				.DW(DW),
				.CW(26),
				.CONV_BASE(CONV_BASE)
			) u_chan (
				.ref_clk(ref_clk),
				.srst(srst),
				.run(run),
				.oversample_ratio(cfg_reg[7*g+3:7*g]),
				.spd_en(cfg_reg[7*g+`SCC_CFG_SPD_BIT]),
				.adc_data(adc_data[DW*g+DW-1:DW*g]),
				.conv_start_reg(conv_start[g]),
				.data_reg(chan_data[DW*g+DW-1:DW*g]),
				.drdy_reg(drdy[g])
			);
		end
	endgenerate

	// events that set sticky status bits
	assign st_set = {
		wr && (avs_address[5:4] == 2'b00) && (wr_osr > `SCC_OSR_CODE_MAX),
		(state_reg == S_TEST) && (test_cnt_reg == `SCC_TEST_CYCLES) &&
			(test_bad_reg || (exc_pwr_good != 4'hF)),
		(state_reg == S_TEST) && (test_cnt_reg == `SCC_TEST_CYCLES),
		drdy
	};

	assign irq = |(status_reg & mask_reg);

	// bus acknowledge and read data
	always @(posedge ref_clk) begin
		if (srst) begin
			ack_reg <= 1'b0;
			avs_readdata <= 32'h00000000;
		end else begin
			ack_reg <= req & ~ack_reg;
			if (avs_read && !ack_reg) begin
				case (avs_address)
					`SCC_ADDR_CH_CFG0: avs_readdata <= {25'h0, cfg_reg[6:0]};
					`SCC_ADDR_CH_CFG1: avs_readdata <= {25'h0, cfg_reg[13:7]};
					`SCC_ADDR_CH_CFG2: avs_readdata <= {25'h0, cfg_reg[20:14]};
					`SCC_ADDR_CH_CFG3: avs_readdata <= {25'h0, cfg_reg[27:21]};
					`SCC_ADDR_STATUS: avs_readdata <= {25'h0, status_reg};
					`SCC_ADDR_MASK: avs_readdata <= {25'h0, mask_reg};
					`SCC_ADDR_HOST_TMO: avs_readdata <= {16'h0000, tmo_reg};
					`SCC_ADDR_DIAG: avs_readdata <= {24'h000000, exc_pwr_good,
						cause_reg, test_bad_reg, run};
					`SCC_ADDR_DATA0: avs_readdata <= {{(32-DW){1'b0}}, chan_data[DW-1:0]};
					`SCC_ADDR_DATA1: avs_readdata <= {{(32-DW){1'b0}}, chan_data[2*DW-1:DW]};
					`SCC_ADDR_DATA2: avs_readdata <= {{(32-DW){1'b0}},
						chan_data[3*DW-1:2*DW]};
					`SCC_ADDR_DATA3: avs_readdata <= {{(32-DW){1'b0}},
						chan_data[4*DW-1:3*DW]};
					default: avs_readdata <= 32'h00000000;
				endcase
			end
		end
	end

	// configuration, excitation, status and mask registers
	integer i;
	integer j;
	always @(posedge ref_clk) begin
		if (srst) begin
			cfg_reg <= {4{`SCC_CFG_RESET}};
			status_reg <= {`SCC_ST_WIDTH{1'b0}};
			mask_reg <= `SCC_MASK_RESET;
			tmo_reg <= `SCC_TMO_RESET;
		end else begin
			for (i = 0; i < 4; i = i + 1) begin
				// per-channel ratio, multiplier and excitation
				if (wr && (avs_address[5:4] == 2'b00) && (avs_address[3:2] == i[1:0])) begin
					// invalid ratio codes leave the old setting in place
					if (wr_osr <= `SCC_OSR_CODE_MAX) begin
						cfg_reg[7*i+:7] <= avs_writedata[6:0];
					end
				end
			end
			if (wr && (avs_address == `SCC_ADDR_MASK)) begin
				mask_reg <= avs_writedata[`SCC_ST_WIDTH-1:0];
			end
			if (wr && (avs_address == `SCC_ADDR_HOST_TMO)) begin
				tmo_reg <= avs_writedata[`SCC_TMO_WIDTH-1:0];
			end
			// write one to clear; a new event in the same cycle wins
			if (wr && (avs_address == `SCC_ADDR_STATUS)) begin
				status_reg <= (status_reg & ~avs_writedata[`SCC_ST_WIDTH-1:0]) | st_set;
			end else begin
				status_reg <= status_reg | st_set;
			end
		end
	end

	// excitation code applied to each supply
	always @(posedge ref_clk) begin
		if (srst) begin
			exc_level <= 8'h00;
		end else begin
			for (j = 0; j < 4; j = j + 1) begin
				exc_level[2*j+:2] <= cfg_reg[7*j+`SCC_CFG_EXC_LSB+:2];
			end
		end
	end

	// self-test sequencer after every reset
	always @(posedge ref_clk) begin
		if (srst) begin
			state_reg <= S_TEST;
			test_cnt_reg <= 5'h00;
			test_bad_reg <= 1'b0;
		end else begin
			case (state_reg)
				S_TEST: begin
					test_cnt_reg <= test_cnt_reg + 5'h01;
					if (exc_pwr_good != 4'hF) begin
						test_bad_reg <= 1'b1;
					end
					if (test_cnt_reg == `SCC_TEST_CYCLES) begin
						state_reg <= (test_bad_reg || (exc_pwr_good != 4'hF)) ? S_FAIL : S_RUN;
					end
				end
				S_RUN: state_reg <= S_RUN;
				S_FAIL: state_reg <= S_FAIL;
				default: state_reg <= state_reg;
			endcase
		end
	end

	// millisecond prescaler shared by supervision timers
	always @(posedge ref_clk) begin
		if (srst) begin
			ms_cnt_reg <= MS_CYCLES - 17'h00001;
		end else if (ms_tick) begin
			ms_cnt_reg <= MS_CYCLES - 17'h00001;
		end else begin
			ms_cnt_reg <= ms_cnt_reg - 17'h00001;
		end
	end

	// watchdog serviced only while the sequencer holds a legal state
	always @(posedge ref_clk) begin
		if (srst) begin
			wd_cnt_reg <= 16'h0000;
			wd_rst_reg <= 1'b0;
		end else if (onehot3(state_reg)) begin
			wd_cnt_reg <= 16'h0000;
			wd_rst_reg <= 1'b0;
		end else if (ms_tick) begin
			wd_cnt_reg <= wd_cnt_reg + 16'h0001;
			wd_rst_reg <= (wd_cnt_reg >= WD_MS);
		end
	end

	// host silence timer, reloaded by every bus access
	always @(posedge ref_clk) begin
		if (srst) begin
			host_cnt_reg <= 16'h0000;
			tmo_rst_reg <= 1'b0;
		end else if (acc) begin
			host_cnt_reg <= 16'h0000;
		end else if (ms_tick) begin
			// silence counted always so the link indicator can time out
			if (host_cnt_reg != 16'hFFFF) begin
				host_cnt_reg <= host_cnt_reg + 16'h0001;
			end
			tmo_rst_reg <= (tmo_reg != `SCC_TMO_RESET) && (host_cnt_reg >= tmo_reg);
		end
	end

	// last reset cause survives module resets, cleared only by rst
	always @(posedge ref_clk) begin
		if (rst) begin
			cause_reg <= 2'b00;
		end else if (wd_rst_reg) begin
			cause_reg <= 2'b01;
		end else if (tmo_rst_reg) begin
			cause_reg <= 2'b10;
		end
	end

	// indicators: power, heartbeat, host link
	always @(posedge ref_clk) begin
		if (srst) begin
			led_power <= 1'b0;
			led_heartbeat <= 1'b0;
			led_comm <= 1'b0;
			hb_cnt_reg <= 16'h0000;
		end else begin
			led_power <= 1'b1;
			if (acc) begin
				led_comm <= 1'b1;
			end else if (ms_tick && (host_cnt_reg >= HB_HALF_MS)) begin
				led_comm <= 1'b0;
			end
			// heartbeat blinks while healthy, lit solid on self-test fault
			if (state_reg == S_FAIL) begin
				led_heartbeat <= 1'b1;
			end else if (ms_tick) begin
				if (hb_cnt_reg >= HB_HALF_MS - 16'h0001) begin
					hb_cnt_reg <= 16'h0000;
					led_heartbeat <= ~led_heartbeat;
				end else begin
					hb_cnt_reg <= hb_cnt_reg + 16'h0001;
				end
			end
		end
	end
endmodule // scc_top

`default_nettype wire

/* verilog/scc_placeholder_none.v */
// intentionally no additional logic
`timescale 1ns/1ns
`default_nettype none
`default_nettype wire

/* bench/scc_assertions.sv */
// assertion checker for the channel controller ports
`timescale 1ns/1ns
`default_nettype none
module scc_checker (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// register bus
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic avs_waitrequest,
	input wire logic irq,
	// channels
	input wire logic [3:0] conv_start,
	input wire logic [7:0] exc_level,
	// indicators
	input wire logic led_power,
	input wire logic led_heartbeat,
	input wire logic led_comm
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (rst);
	a_bus_one_wait: assert property ((avs_read | avs_write) && avs_waitrequest |=> !avs_waitrequest)
		else $error("bus wait longer than one cycle");
	a_reset_quiet: assert property (disable iff (1'b0) rst |=> conv_start == 4'h0 && exc_level == 8'h00 && !irq)
		else $error("outputs active during reset");
	a_power_on: assert property ($fell(rst) |=> led_power)
		else $error("power indicator off after reset");
	a_test_quiet: assert property ($fell(rst) |-> conv_start == 4'h0 [*8])
		else $error("conversion during self test");
	a_conv_pulse: assert property ((conv_start & $past(conv_start)) == 4'h0)
		else $error("conversion start longer than one cycle");
	a_conv_spacing: assert property (conv_start[0] |=> !conv_start[0] [*3])
		else $error("conversions too close");
	a_exc_cause: assert property (exc_level != $past(exc_level) |-> $past(avs_write) || $past(avs_write, 2) || exc_level == 8'h00)
		else $error("excitation changed without a write");
	a_hb_steady: assert property ($changed(led_heartbeat) |=> ($stable(led_heartbeat) || !led_power) [*8])
		else $error("heartbeat toggles too fast");
	a_comm_led: assert property ((avs_read | avs_write) && !avs_waitrequest |=> ##[0:2] led_comm)
		else $error("comm indicator not set by access");
	c_irq: cover property (irq);
	c_conv3: cover property (conv_start[3]);
	c_hb: cover property ($fell(led_heartbeat));
endmodule // scc_checker
bind scc_top scc_checker u_chk (.ref_clk, .rst, .avs_read, .avs_write, .avs_waitrequest, .irq,
	.conv_start, .exc_level, .led_power, .led_heartbeat, .led_comm);
`default_nettype wire

/* bench/scc_front.sv */
// converter and excitation supply model for the four channels
`timescale 1ns/1ns
`default_nettype none
module scc_front (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst,
	// channel side
	input wire logic [3:0] conv_start,
	input wire logic [3:0] pg_fault,
	output logic [95:0] adc_data,
	output logic [3:0] exc_pwr_good
);
	// each converter counts its own conversions
	always @(posedge ref_clk) begin
		for (int g = 0; g < 4; g++) begin
			if (rst)
				adc_data[24 * g +: 24] <= 24'h000000;
			else if (conv_start[g])
				adc_data[24 * g +: 24] <= adc_data[24 * g +: 24] + 24'h000001;
		end
	end
	// every programmed level is held good unless a fault is forced
	assign exc_pwr_good = ~pg_fault;
endmodule // scc_front
`default_nettype wire

/* bench/scc_top_test.sv */
// self-checking bench for the channel controller
`timescale 1ns/1ns
`default_nettype none
`include "scc_map.vh"
module scc_top_test;
	logic ref_clk = 1'b0;
	logic rst = 1'b1;
	logic [5:0] avs_address = 6'h00;
	logic avs_read = 1'b0;
	logic avs_write = 1'b0;
	logic [31:0] avs_writedata = 32'h00000000;
	logic [3:0] pg_fault = 4'h0;
	wire [31:0] avs_readdata;
	wire avs_waitrequest;
	wire irq;
	wire [95:0] adc_data;
	wire [3:0] conv_start;
	wire [7:0] exc_level;
	wire [3:0] exc_pwr_good;
	wire led_power;
	wire led_heartbeat;
	wire led_comm;
	logic [31:0] exp_q[$];
	logic [3:0] code [4];
	logic spd [4];
	int errors = 0;
	int checked = 0;
	int seed = 32'h0000B166;
	int n;
	scc_top #(.CONV_BASE(26'h8), .MS_CYCLES(17'hA), .HB_HALF_MS(16'h3)) u_dut (.ref_clk, .rst,
		.avs_address, .avs_read, .avs_write, .avs_writedata, .avs_readdata, .avs_waitrequest,
		.irq, .adc_data, .conv_start, .exc_level, .exc_pwr_good, .led_power, .led_heartbeat,
		.led_comm);
	scc_front u_fe (.ref_clk, .rst, .conv_start, .pg_fault, .adc_data, .exc_pwr_good);
	initial forever #4 ref_clk = ~ref_clk;
	task cmp(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task summarize;
		$display("checked %0d errors %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task acc(input logic w, input logic [5:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		avs_address <= a;
		avs_read <= ~w;
		avs_write <= w;
		avs_writedata <= d;
		// hold the request until waitrequest is seen low at a rising edge
		do @(posedge ref_clk);
		while (avs_waitrequest !== 1'b0);
		avs_read <= 1'b0;
		avs_write <= 1'b0;
	endtask
	task rd(input logic [5:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		acc(1'b0, a, 32'h00000000);
	endtask
	// g below 4 waits for a conversion start, 4 for a heartbeat edge
	task wait_ev(input int g);
		logic v;
		v = led_heartbeat;
		n = 0;
		do begin
			@(posedge ref_clk);
			#1 n++;
		end while ((g < 4 ? conv_start[g] !== 1'b1 : led_heartbeat === v) && n < 9000);
	endtask
	// read results are taken at the accept edge
	always @(posedge ref_clk) begin
		if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
			cmp(avs_readdata, exp_q.pop_front());
	end
	initial begin
		#400000;
		errors++;
		summarize;
	end
	initial begin
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (30) @(posedge ref_clk);
		rd(`SCC_ADDR_DIAG, 32'h000000F1);
		rd(`SCC_ADDR_STATUS, 32'h0000001F);
		for (int g = 0; g < 4; g++) begin
			code[g] = 4'({$random(seed)} % 10);
			spd[g] = 1'($random(seed));
			acc(1'b1, 6'(4 * g), {25'h0, 2'(g), spd[g], code[g]});
			rd(6'(4 * g), {25'h0, 2'(g), spd[g], code[g]});
		end
		cmp({24'h0, exc_level}, 32'h000000E4);
		for (int g = 0; g < 4; g++) begin
			wait_ev(g);
			wait_ev(g);
			cmp(n, (32'h8 << code[g]) >> spd[g]);
			rd(`SCC_ADDR_DATA0 + 6'(4 * g), {8'h00, adc_data[24 * g +: 24] - 24'(spd[g])});
		end
		acc(1'b1, `SCC_ADDR_CH_CFG0, {25'h0, 3'h3, 4'hA + 4'({$random(seed)} % 6)});
		rd(`SCC_ADDR_CH_CFG0, {25'h0, 2'h0, spd[0], code[0]});
		acc(1'b1, `SCC_ADDR_MASK, 32'h00000000);
		#1 cmp({31'h0, irq}, 32'h00000000);
		acc(1'b1, `SCC_ADDR_MASK, 32'h00000040);
		#1 cmp({31'h0, irq}, 32'h00000001);
		rd(`SCC_ADDR_MASK, 32'h00000040);
		acc(1'b1, `SCC_ADDR_STATUS, 32'h00000040);
		#1 cmp({31'h0, irq}, 32'h00000000);
		acc(1'b1, 6'h3C, 32'hFFFFFFFF);
		rd(6'h3C, 32'h00000000);
		cmp({31'h0, led_comm}, 32'h00000001);
		wait_ev(4);
		wait_ev(4);
		cmp(n, 32'h0000001E);
		repeat (12) @(posedge ref_clk);
		#1 cmp({31'h0, led_comm}, 32'h00000000);
		acc(1'b1, `SCC_ADDR_HOST_TMO, 32'h00000002);
		repeat (80) @(posedge ref_clk);
		rd(`SCC_ADDR_DIAG, 32'h000000F9);
		rd(`SCC_ADDR_CH_CFG0, 32'h00000000);
		@(posedge ref_clk);
		rst <= 1'b1;
		pg_fault <= 4'h8;
		repeat (16) @(posedge ref_clk);
		rst <= 1'b0;
		repeat (30) @(posedge ref_clk);
		rd(`SCC_ADDR_DIAG, 32'h00000072);
		cmp({31'h0, led_heartbeat}, 32'h00000001);
		summarize;
	end
endmodule // scc_top_test
`default_nettype wire
